//--- shared/pfcmc_consts.svh
// register offsets, field positions, reset values and fixed figures of the clock mode control
// assumes: included by bare name wherever a figure is needed
`ifndef PFCMC_CONSTS_SVH
`define PFCMC_CONSTS_SVH

// ==========================================================================
// register byte offsets
`define PFCMC_OFS_PLL_CTRL   8'h00
`define PFCMC_OFS_SRC_CTRL   8'h04
`define PFCMC_OFS_AUX_CTRL   8'h08
`define PFCMC_OFS_STATUS     8'h0c

// ==========================================================================
// pll control register fields
`define PFCMC_LOSS_IRQ_EN_BIT 7
`define PFCMC_PLL_SEL_BIT    6
`define PFCMC_MON_EN_BIT     5
`define PFCMC_MULT_SEL_MSB   3
`define PFCMC_MULT_SEL_LSB   0
`define PFCMC_PLL_CTRL_WMASK 8'hef
`define PFCMC_PLL_CTRL_RST   8'h01

// source control register fields
`define PFCMC_SRC_SEL_MSB    7
`define PFCMC_SRC_SEL_LSB    6
`define PFCMC_REF_DIV_MSB    5
`define PFCMC_REF_DIV_LSB    3
`define PFCMC_INT_REF_BIT    2
`define PFCMC_SRC_CTRL_WMASK 8'hfc
`define PFCMC_SRC_CTRL_RST   8'h04

// auxiliary control register fields
`define PFCMC_LOW_PWR_BIT    3
`define PFCMC_EXT_REF_EN_BIT 2
`define PFCMC_AUX_CTRL_WMASK 8'h0c
`define PFCMC_AUX_CTRL_RST   8'h00

// status register fields
`define PFCMC_LOSS_FLAG_BIT  7
`define PFCMC_LOCK_BIT       6
`define PFCMC_PLL_STAT_BIT   5
`define PFCMC_INT_REF_STAT_BIT 4
`define PFCMC_SRC_STAT_MSB   3
`define PFCMC_SRC_STAT_LSB   2

// ==========================================================================
// fixed figures
`define PFCMC_MULT_STEP      6'h04
`define PFCMC_MULT_MAX       6'h28
`define PFCMC_MULT_SEL_TOP   4'ha
`define PFCMC_FLL_RATIO      11'h400
`define PFCMC_REF_DIV_NONE   3'h0

`endif

//--- shared/pfcmc_pkg.sv
// types shared by the clock mode control modules
// assumes: compiled before the interface and the design modules
package pfcmc_pkg;

  // ==========================================================================
  // operating states of the clock generator
  typedef enum logic [3:0] {
    PFCMC_FLL_ENG_INT  = 4'h0,
    PFCMC_FLL_ENG_EXT  = 4'h1,
    PFCMC_FLL_BYP_INT  = 4'h2,
    PFCMC_FLL_BYP_EXT  = 4'h3,
    PFCMC_PLL_ENG_EXT  = 4'h4,
    PFCMC_PLL_BYP_EXT  = 4'h5,
    PFCMC_LOWP_BYP_INT = 4'h6,
    PFCMC_LOWP_BYP_EXT = 4'h7,
    PFCMC_STOP = 4'h8
  } pfcmc_mode_t;

  // clock source encodings, shared by select and status
  typedef enum logic [1:0] {
    PFCMC_SRC_FLL = 2'h0,
    PFCMC_SRC_INT = 2'h1,
    PFCMC_SRC_EXT = 2'h2,
    PFCMC_SRC_PLL = 2'h3
  } pfcmc_src_t;

endpackage : pfcmc_pkg

//--- shared/pfcmc_cfg_if.sv
// carries software mode settings to the mode tracker and the tracked mode back
// assumes: one register side and one tracker side
interface pfcmc_cfg_if
  import pfcmc_pkg::*;
  ();
  logic [1:0]  clock_source_select;
  logic        internal_ref_select;
  logic        pll_select;
  logic [2:0]  reference_divider;
  logic        low_power_bypass;
  logic        bdm_active;
  logic        stop_req;
  pfcmc_mode_t mode;

  modport ctl (
    output clock_source_select, internal_ref_select, pll_select, reference_divider,
    output low_power_bypass, bdm_active, stop_req,
    input  mode
  );
  modport fsm (
    input  clock_source_select, internal_ref_select, pll_select, reference_divider,
    input  low_power_bypass, bdm_active, stop_req,
    output mode
  );
endinterface : pfcmc_cfg_if

//--- logic/pfcmc_status_sync.sv
// status synchroniser: select bits reach the status fields only after three register stages
// assumes: CLK domain settings in, ext_ready synchronous to CLK
`include "pfcmc_consts.svh"
module pfcmc_status_sync
  import pfcmc_pkg::*;
  (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic [1:0] src_sel,
  input  wire logic       int_ref_sel,
  input  wire logic       pll_sel,
  input  wire logic       ext_ready,
  output pfcmc_src_t      src_stat,
  output logic            int_ref_stat,
  output logic            pll_stat
);
  // ==========================================================================
  // two-stage chain; stage one is read only by stage two
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  pfcmc_src_t want;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= {2'h0, 1'b1, 1'b0};
      sync_q <= {2'h0, 1'b1, 1'b0};
    end else if (ce) begin
      meta_q <= {src_sel, int_ref_sel, pll_sel};
      sync_q <= meta_q;
    end
  end

  always_comb begin
    unique case (sync_q[3:2])
      2'h0:    want = sync_q[0] ? PFCMC_SRC_PLL : PFCMC_SRC_FLL;
      2'h1:    want = PFCMC_SRC_INT;
      default: want = PFCMC_SRC_EXT;
    endcase
  end

  // ==========================================================================
  // a missing external clock leaves the previous source selected
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_stat     <= PFCMC_SRC_FLL;
      int_ref_stat <= 1'b1;
      pll_stat     <= 1'b0;
    end else if (ce) begin
      if (want != PFCMC_SRC_EXT || ext_ready) begin
        src_stat <= want;
      end
      int_ref_stat <= sync_q[1];
      pll_stat     <= sync_q[0];
    end
  end
endmodule : pfcmc_status_sync

//--- logic/pfcmc_mode_fsm.sv
// mode tracker: decodes the requested mode and moves only along allowed arcs
// assumes: settings come from the register side through the carrier interface
`include "pfcmc_consts.svh"
module pfcmc_mode_fsm
  import pfcmc_pkg::*;
  (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  pfcmc_cfg_if.fsm  cfg
);
  pfcmc_mode_t mode_q;
  pfcmc_mode_t mode_d;
  pfcmc_mode_t saved_q;
  pfcmc_mode_t target;
  logic        target_ok;
  logic        div_none;

  assign div_none = (cfg.reference_divider == `PFCMC_REF_DIV_NONE);
  assign cfg.mode  = mode_q;

  // ==========================================================================
  // requested mode; an unmatched setting leaves the mode where it is
  always_comb begin
    target    = mode_q;
    target_ok = 1'b0;
    unique case (cfg.clock_source_select)
      2'h0: begin
        target_ok = ~cfg.internal_ref_select | (~cfg.pll_select & div_none);
        if (cfg.internal_ref_select) begin
          target = PFCMC_FLL_ENG_INT;
        end else begin
          target = cfg.pll_select ? PFCMC_PLL_ENG_EXT : PFCMC_FLL_ENG_EXT;
        end
      end
      2'h1: begin
        target_ok = cfg.internal_ref_select & ~cfg.pll_select;
        if (cfg.low_power_bypass && !cfg.bdm_active) begin
          target = PFCMC_LOWP_BYP_INT;
        end else begin
          target    = PFCMC_FLL_BYP_INT;
          target_ok = target_ok & div_none;
        end
      end
      2'h2: begin
        target_ok = ~cfg.internal_ref_select;
        if (cfg.low_power_bypass && !cfg.bdm_active) begin
          target = PFCMC_LOWP_BYP_EXT;
        end else begin
          target = cfg.pll_select ? PFCMC_PLL_BYP_EXT : PFCMC_FLL_BYP_EXT;
        end
      end
      default: target_ok = 1'b0;
    endcase
  end

  // ==========================================================================
  // arcs of the nine-state graph, both directions
  function automatic logic arc_ok(input pfcmc_mode_t a, input pfcmc_mode_t b);
    logic [8:0] reach;
    reach = 9'h000;
    unique case (a)
      PFCMC_FLL_ENG_INT:  reach = 9'h00e;
      PFCMC_FLL_ENG_EXT:  reach = 9'h00d;
      PFCMC_FLL_BYP_INT:  reach = 9'h04b;
      PFCMC_FLL_BYP_EXT:  reach = 9'h0a7;
      PFCMC_PLL_ENG_EXT:  reach = 9'h020;
      PFCMC_PLL_BYP_EXT:  reach = 9'h098;
      PFCMC_LOWP_BYP_INT: reach = 9'h004;
      PFCMC_LOWP_BYP_EXT: reach = 9'h028;
      default:    reach = 9'h000;
    endcase
    arc_ok = reach[b] | (a == b);
  endfunction : arc_ok

  always_comb begin
    mode_d = mode_q;
    if (mode_q == PFCMC_STOP) begin
      if (!cfg.stop_req) begin
        mode_d = saved_q;
      end
    end else if (cfg.stop_req) begin
      mode_d = PFCMC_STOP;
    end else if (target_ok && arc_ok(mode_q, target)) begin
      mode_d = target;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= PFCMC_FLL_ENG_INT;
    end else if (ce) begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      saved_q <= PFCMC_FLL_ENG_INT;
    end else if (ce && cfg.stop_req && mode_q != PFCMC_STOP) begin
      saved_q <= mode_q;
    end
  end
endmodule : pfcmc_mode_fsm

//--- logic/pfcmc_top.sv
// clock mode control: apb registers, loop enables, output source and lock-loss tracking
// assumes: all inputs synchronous to CLK; loops, oscillators and clock muxes lie outside
//
// How it works
// - irq when lock-loss flag and enable set
// - pll select disables the other loop
// - monitor enable turns clock loss into reset
// - multiplier equals four times code one..ten
// - code zero reserved, higher codes mean forty
// - reset lands in fll engaged internal
// - engaged internal output comes from fll
// - engaged external entry; software sets divided reference
// - engaged external output comes from fll
// - bypassed internal entry needs low power cleared
// - bypassed internal outputs internal reference, fll runs
// - bypassed external entry needs low power cleared
// - bypassed external outputs external reference, fll runs
// - fll modes: local clock fll, pll off
// - nine states, only allowed moves
// - lock-loss flag sticky, cleared by writing one
// - source status follows select after synchronisation
`include "pfcmc_consts.svh"
module pfcmc_top
  import pfcmc_pkg::*;
  (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        FLL_LOCKED,
  input  wire logic        PLL_LOCKED,
  input  wire logic        EXT_CLK_LOST,
  input  wire logic        EXT_REF_READY,
  input  wire logic        BDM_ACTIVE,
  input  wire logic        STOP_REQ,
  output logic             LOCK_LOSS_IRQ,
  output logic             CLOCK_MONITOR_RESET_REQ,
  output logic             FLL_ENABLE,
  output logic             PLL_ENABLE,
  output logic      [5:0]  PLL_MULT,
  output logic      [10:0] FLL_RATIO,
  output logic      [1:0]  OUT_CLK_SEL,
  output logic             LOCAL_CLK_FROM_FLL,
  output logic      [3:0]  MODE
);
  // ==========================================================================
  // apb slave: one wait state, so read data can come from a flop
  logic [7:0]  pll_ctrl_q;
  logic [7:0]  src_ctrl_q;
  logic [7:0]  aux_ctrl_q;
  logic        loss_flag_q;
  logic        lock_prev_q;
  logic [7:0]  status;
  logic [7:0]  rd_byte;
  logic        rd_hit;
  logic        acc;
  logic        wr_fire;
  logic [7:0]  wbyte;
  logic        lock_now;
  logic        det_en;
  logic        loss_set;
  logic        loss_clr;
  pfcmc_src_t  src_stat;
  logic        int_ref_stat;
  logic        pll_stat;
  pfcmc_mode_t mode;
  logic        fll_on;
  logic        pll_on;
  pfcmc_src_t  sel_d;
  logic [3:0]  mult_code;
  logic [5:0]  mult_d;

  pfcmc_cfg_if cfg ();

  assign acc     = PSEL & PENABLE;
  assign wr_fire = acc & PREADY & PWRITE;
  assign wbyte   = PWDATA[7:0];

  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    unique case (PADDR)
      `PFCMC_OFS_PLL_CTRL: rd_byte = pll_ctrl_q;
      `PFCMC_OFS_SRC_CTRL: rd_byte = src_ctrl_q;
      `PFCMC_OFS_AUX_CTRL: rd_byte = aux_ctrl_q;
      `PFCMC_OFS_STATUS:   rd_byte = status;
      default:             rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      if (acc && !PREADY) begin
        PREADY  <= 1'b1;
        PRDATA  <= PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        PSLVERR <= ~rd_hit;
      end else begin
        PREADY  <= 1'b0;
        PRDATA  <= 32'h0000_0000;
        PSLVERR <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // control registers; unused bits are masked off on write
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pll_ctrl_q <= `PFCMC_PLL_CTRL_RST;
    end else if (CE && wr_fire && PADDR == `PFCMC_OFS_PLL_CTRL) begin
      pll_ctrl_q <= wbyte & `PFCMC_PLL_CTRL_WMASK;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      src_ctrl_q <= `PFCMC_SRC_CTRL_RST;
    end else if (CE && wr_fire && PADDR == `PFCMC_OFS_SRC_CTRL) begin
      src_ctrl_q <= wbyte & `PFCMC_SRC_CTRL_WMASK;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      aux_ctrl_q <= `PFCMC_AUX_CTRL_RST;
    end else if (CE && wr_fire && PADDR == `PFCMC_OFS_AUX_CTRL) begin
      aux_ctrl_q <= wbyte & `PFCMC_AUX_CTRL_WMASK;
    end
  end

  // ==========================================================================
  // mode tracking and status synchronisation
  assign cfg.clock_source_select = src_ctrl_q[`PFCMC_SRC_SEL_MSB:`PFCMC_SRC_SEL_LSB];
  assign cfg.reference_divider   = src_ctrl_q[`PFCMC_REF_DIV_MSB:`PFCMC_REF_DIV_LSB];
  assign cfg.internal_ref_select = src_ctrl_q[`PFCMC_INT_REF_BIT];
  assign cfg.pll_select          = pll_ctrl_q[`PFCMC_PLL_SEL_BIT];
  assign cfg.low_power_bypass    = aux_ctrl_q[`PFCMC_LOW_PWR_BIT];
  assign cfg.bdm_active          = BDM_ACTIVE;
  assign cfg.stop_req            = STOP_REQ;
  assign mode                    = cfg.mode;

  pfcmc_mode_fsm u_fsm (
    .clk   (CLK),
    .rst_n (RST_N),
    .ce    (CE),
    .cfg   (cfg.fsm)
  );

  pfcmc_status_sync u_sync (
    .clk       (CLK),
    .rst_n     (RST_N),
    .ce        (CE),
    .src_sel      (cfg.clock_source_select),
    .int_ref_sel  (cfg.internal_ref_select),
    .pll_sel      (cfg.pll_select),
    .ext_ready    (EXT_REF_READY),
    .src_stat     (src_stat),
    .int_ref_stat (int_ref_stat),
    .pll_stat     (pll_stat)
  );

  assign status = {loss_flag_q, lock_now, pll_stat, int_ref_stat, src_stat, 2'h0};

  // ==========================================================================
  // loop enables and output clock selection per tracked mode
  always_comb begin
    fll_on = 1'b0;
    pll_on = 1'b0;
    sel_d  = PFCMC_SRC_FLL;
    unique case (mode)
      PFCMC_FLL_ENG_INT, PFCMC_FLL_ENG_EXT: begin
        fll_on = 1'b1;
        sel_d  = PFCMC_SRC_FLL;
      end
      PFCMC_FLL_BYP_INT: begin
        fll_on = 1'b1;
        sel_d  = PFCMC_SRC_INT;
      end
      PFCMC_FLL_BYP_EXT: begin
        fll_on = 1'b1;
        sel_d  = PFCMC_SRC_EXT;
      end
      PFCMC_PLL_ENG_EXT: begin
        pll_on = 1'b1;
        sel_d  = PFCMC_SRC_PLL;
      end
      PFCMC_PLL_BYP_EXT: begin
        pll_on = 1'b1;
        sel_d  = PFCMC_SRC_EXT;
      end
      PFCMC_LOWP_BYP_INT: sel_d = PFCMC_SRC_INT;
      PFCMC_LOWP_BYP_EXT: sel_d = PFCMC_SRC_EXT;
      default: begin
        fll_on = 1'b0;
        pll_on = 1'b0;
        sel_d  = PFCMC_SRC_FLL;
      end
    endcase
    // the select bit overrides the mode so the unselected loop never runs
    fll_on = fll_on & ~cfg.pll_select;
    pll_on = pll_on & cfg.pll_select;
  end

  // ==========================================================================
  // multiplier: reserved upper codes saturate at forty, zero gives no factor
  assign mult_code = pll_ctrl_q[`PFCMC_MULT_SEL_MSB:`PFCMC_MULT_SEL_LSB];

  always_comb begin
    if (mult_code == 4'h0) begin
      mult_d = 6'h00;
    end else if (mult_code > `PFCMC_MULT_SEL_TOP) begin
      mult_d = `PFCMC_MULT_MAX;
    end else begin
      mult_d = 6'({2'h0, mult_code} * `PFCMC_MULT_STEP);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      FLL_ENABLE         <= 1'b1;
      PLL_ENABLE         <= 1'b0;
      OUT_CLK_SEL        <= PFCMC_SRC_FLL;
      LOCAL_CLK_FROM_FLL <= 1'b1;
      MODE               <= PFCMC_FLL_ENG_INT;
      PLL_MULT           <= 6'h00;
      FLL_RATIO          <= `PFCMC_FLL_RATIO;
    end else if (CE) begin
      FLL_ENABLE         <= fll_on;
      PLL_ENABLE         <= pll_on;
      OUT_CLK_SEL        <= sel_d;
      LOCAL_CLK_FROM_FLL <= fll_on;
      MODE               <= mode;
      PLL_MULT           <= mult_d;
      FLL_RATIO          <= `PFCMC_FLL_RATIO;
    end
  end

  // ==========================================================================
  // lock-loss: sticky, set wins over a same-cycle write-one clear
  assign lock_now = PLL_ENABLE ? PLL_LOCKED : (FLL_ENABLE & FLL_LOCKED);
  assign det_en   = FLL_ENABLE | PLL_ENABLE;
  assign loss_set = det_en & lock_prev_q & ~lock_now;
  assign loss_clr = wr_fire & (PADDR == `PFCMC_OFS_STATUS) & wbyte[`PFCMC_LOSS_FLAG_BIT];

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      lock_prev_q <= 1'b0;
    end else if (CE) begin
      lock_prev_q <= lock_now & det_en;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      loss_flag_q <= 1'b0;
    end else if (CE) begin
      if (loss_set) begin
        loss_flag_q <= 1'b1;
      end else if (loss_clr) begin
        loss_flag_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // request outputs; the monitor request is a level while loss persists
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      LOCK_LOSS_IRQ           <= 1'b0;
      CLOCK_MONITOR_RESET_REQ <= 1'b0;
    end else if (CE) begin
      LOCK_LOSS_IRQ           <= loss_flag_q & pll_ctrl_q[`PFCMC_LOSS_IRQ_EN_BIT];
      CLOCK_MONITOR_RESET_REQ <= EXT_CLK_LOST & pll_ctrl_q[`PFCMC_MON_EN_BIT];
    end
  end

endmodule : pfcmc_top

//--- test/pfcmc_checker.sv
// checker: apb timing, loop enables, multiplier, output source and lock-loss request
// assumes: bound to pfcmc_top, CE held high for the whole run
module pfcmc_checker
  import pfcmc_pkg::*;
  (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        CE,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        EXT_CLK_LOST,
  input wire logic        LOCK_LOSS_IRQ,
  input wire logic        CLOCK_MONITOR_RESET_REQ,
  input wire logic        FLL_ENABLE,
  input wire logic        PLL_ENABLE,
  input wire logic [5:0]  PLL_MULT,
  input wire logic [10:0] FLL_RATIO,
  input wire logic [1:0]  OUT_CLK_SEL,
  input wire logic        LOCAL_CLK_FROM_FLL,
  input wire logic [3:0]  MODE
);
  // ==========
  // shadow of the pll control register, kept from completed apb writes
  logic [7:0] ctl_q;
  logic       irq_en;
  logic       mon_cause;
  logic       pll_sel;
  logic [3:0] code;
  assign irq_en    = ctl_q[7];
  assign pll_sel   = ctl_q[6];
  assign mon_cause = EXT_CLK_LOST && ctl_q[5];
  assign code      = ctl_q[3:0];
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctl_q <= 8'h01;
    end else if (CE && PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h00) begin
      ctl_q <= PWDATA[7:0] & 8'hef;
    end
  end
  function automatic logic [5:0] mult_of(input logic [3:0] c);
    return (c == 4'h0) ? 6'h00 : (c > 4'ha) ? 6'h28 : {c, 2'b00};
  endfunction : mult_of
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // ==========
  // assertions
  a_irq_enable: assert property (LOCK_LOSS_IRQ |-> $past(irq_en))
    else $error("irq raised without enable");
  a_monitor_req: assert property ($past(RST_N) |-> CLOCK_MONITOR_RESET_REQ == $past(mon_cause))
    else $error("monitor reset request wrong");
  a_loop_excl: assert property (!(FLL_ENABLE && PLL_ENABLE))
    else $error("both loops enabled");
  a_pll_off: assert property ((!pll_sel)[*3] |-> !PLL_ENABLE)
    else $error("pll on without select");
  a_mult_code: assert property ($past(RST_N) |-> PLL_MULT == mult_of($past(code)))
    else $error("multiplier wrong");
  a_fll_ratio: assert property (FLL_RATIO == 11'h400)
    else $error("fll ratio wrong");
  a_ctl_read: assert property (PREADY && !PWRITE && PADDR == 8'h00 |-> PRDATA == {24'h0, ctl_q})
    else $error("control readback wrong");
  a_src_mode: assert property ((!pll_sel)[*3] ##0 MODE < 4'h4
    |-> OUT_CLK_SEL == (MODE[1] ? {MODE[0], !MODE[0]} : 2'h0))
    else $error("output source does not match mode");
  a_fll_local: assert property ((!pll_sel)[*3] ##0 MODE < 4'h4
    |-> LOCAL_CLK_FROM_FLL && FLL_ENABLE && !PLL_ENABLE)
    else $error("fll mode enables wrong");
  a_reset_mode: assert property ($rose(RST_N) |-> MODE == 4'h0)
    else $error("mode after reset wrong");
  a_apb_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("ready timing wrong");
  a_unmapped: assert property (PREADY && PADDR > 8'h0c |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
endmodule : pfcmc_checker

bind pfcmc_top pfcmc_checker u_pfcmc_checker (.CLK(CLK), .RST_N(RST_N), .CE(CE),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .EXT_CLK_LOST(EXT_CLK_LOST),
  .LOCK_LOSS_IRQ(LOCK_LOSS_IRQ), .CLOCK_MONITOR_RESET_REQ(CLOCK_MONITOR_RESET_REQ),
  .FLL_ENABLE(FLL_ENABLE), .PLL_ENABLE(PLL_ENABLE), .PLL_MULT(PLL_MULT),
  .FLL_RATIO(FLL_RATIO), .OUT_CLK_SEL(OUT_CLK_SEL),
  .LOCAL_CLK_FROM_FLL(LOCAL_CLK_FROM_FLL), .MODE(MODE));

//--- test/testbench.sv
// testbench of the clock mode control: apb master, loop status pins, port checks
// assumes: pfcmc_top with its checker bound; CE and reference-ready held high
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module testbench
  import pfcmc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_n, psel, penable, pwrite, fll_lk, clk_lost, stop, er;
  logic        pready, pslverr, irq, mon_req, fll_en, pll_en, loc_fll;
  logic [7:0]  paddr, d;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  mult;
  logic [10:0] ratio;
  logic [1:0]  osel;
  logic [3:0]  mode;
  int          n_errors = 0;
  int          n_compared = 0;
  logic [7:0]  rst_tab[4] = '{8'h01, 8'h04, 8'h00, 8'h10};
  logic [7:0]  mt_src[8]  = '{8'h44, 8'h04, 8'h18, 8'h98, 8'h04, 8'h4c, 8'h44, 8'h44};
  logic [7:0]  mt_aux[8]  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00};
  logic [3:0]  mt_mode[8] = '{4'h2, 4'h0, 4'h1, 4'h3, 4'h0, 4'h0, 4'h0, 4'h2};

  pfcmc_top u_pfcmc_top (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FLL_LOCKED(fll_lk), .PLL_LOCKED(1'b0),
    .EXT_CLK_LOST(clk_lost), .EXT_REF_READY(1'b1), .BDM_ACTIVE(1'b0), .STOP_REQ(stop),
    .LOCK_LOSS_IRQ(irq), .CLOCK_MONITOR_RESET_REQ(mon_req), .FLL_ENABLE(fll_en),
    .PLL_ENABLE(pll_en), .PLL_MULT(mult), .FLL_RATIO(ratio), .OUT_CLK_SEL(osel),
    .LOCAL_CLK_FROM_FLL(loc_fll), .MODE(mode));

  initial begin
    forever begin
      #20 clk = ~clk;
    end
  end

  // ==========
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // waits for ready with no assumed latency; read data is taken at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_errors++;
      $display("[ERR] %0t no ready", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic lose_lock();
    @(posedge clk);
    fll_lk <= 1'b1;
    cyc(4);
    @(posedge clk);
    fll_lk <= 1'b0;
    cyc(3);
  endtask : lose_lock

  function automatic logic [5:0] mult_exp(input logic [3:0] c);
    return (c == 4'h0) ? 6'h00 : (c > 4'ha) ? 6'h28 : 6'(c * 4);
  endfunction : mult_exp

  function automatic logic [1:0] src_exp(input logic [3:0] m);
    return m[1] ? {m[0], ~m[0]} : 2'h0;
  endfunction : src_exp

  task automatic close_out();
    if (n_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  initial begin
    #800000;
    n_errors++;
    close_out();
  end

  // ==========
  // tests
  initial begin
    {rst_n, psel, penable, pwrite, fll_lk, clk_lost, stop} = 7'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(32'h8238));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    cyc(2);
    `CHK(mode, 4'h0)
    `CHK({fll_en, pll_en, loc_fll}, 3'b101)
    `CHK({mult, ratio}, {6'h04, 11'h400})
    foreach (rst_tab[i]) begin
      apb(1'b0, 8'(i * 4), 8'h00);
      `CHK(rd, {24'h0, rst_tab[i]})
    end
    repeat (4) begin
      d = 8'($urandom);
      apb(1'b1, 8'h00, d);
      apb(1'b0, 8'h00, 8'h00);
      `CHK(rd[7:0], d & 8'hef)
    end
    apb(1'b1, 8'h00, 8'h41);
    cyc(4);
    `CHK({pll_en, fll_en}, 2'b00)
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, 8'h00, 8'(c));
      cyc(2);
      `CHK({pll_en, fll_en}, 2'b01)
      `CHK(mult, mult_exp(4'(c)))
    end
    repeat (3) begin
      d = 8'h10 + 8'($urandom_range(0, 59)) * 8'h04;
      apb(1'b1, d, 8'hff);
      apb(1'b0, d, 8'h00);
      `CHK({er, rd}, {1'b1, 32'h0})
    end
    apb(1'b1, 8'h00, 8'h81);
    lose_lock();
    `CHK(irq, 1'b1)
    cyc(3);
    apb(1'b0, 8'h0c, 8'h00);
    `CHK({irq, rd[7]}, 2'b11)
    apb(1'b1, 8'h0c, 8'h80);
    cyc(2);
    `CHK(irq, 1'b0)
    apb(1'b1, 8'h00, 8'h01);
    lose_lock();
    apb(1'b0, 8'h0c, 8'h00);
    `CHK({irq, rd[7]}, 2'b01)
    apb(1'b1, 8'h0c, 8'h80);
    foreach (mt_src[i]) begin
      apb(1'b1, 8'h08, mt_aux[i]);
      apb(1'b1, 8'h04, mt_src[i]);
      cyc(4);
      `CHK(mode, mt_mode[i])
      `CHK(osel, src_exp(mt_mode[i]))
      `CHK({loc_fll, pll_en}, 2'b10)
      apb(1'b0, 8'h0c, 8'h00);
      if (i != 5 && i != 6) `CHK(rd[4:2], {mt_src[i][2], mt_src[i][7:6]})
    end
    @(posedge clk);
    stop <= 1'b1;
    cyc(4);
    `CHK(mode, 4'h8)
    @(posedge clk);
    stop <= 1'b0;
    cyc(4);
    `CHK(mode, 4'h2)
    // monitor is armed in an external mode, multiplier code left alone
    apb(1'b1, 8'h04, 8'h98);
    apb(1'b1, 8'h00, 8'h21);
    repeat (20) begin
      @(posedge clk);
      clk_lost <= 1'($urandom);
    end
    @(posedge clk);
    clk_lost <= 1'b1;
    cyc(2);
    `CHK(mon_req, 1'b1)
    apb(1'b1, 8'h00, 8'h01);
    cyc(2);
    `CHK(mon_req, 1'b0)
    close_out();
  end
endmodule : testbench
